/* File: mca_pkg.sv */
// Constants, opcodes and state layout of the core execution datapath.
package mca_pkg;
    localparam int PC_W = 12;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int CLKS_PER_ICYCLE = 4;
    localparam logic [1:0] PHASE_LAST = 2'(CLKS_PER_ICYCLE - 1);
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFF_CMD = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_OPND = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_TABLE = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_WREG = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_RESULT = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_PC = 5'h18;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_TOMEM = 5;
    localparam int CMD_TOPCL = 6;
    localparam int CMD_BIT_LSB = 8;
    localparam int CMD_TGT_LSB = 16;
    localparam int ST_Z = 0;
    localparam int ST_C = 1;
    localparam int ST_NIB = 2;
    localparam int ST_SGN = 3;
    localparam int ST_GATE = 4;
    localparam int ST_BUSY = 5;
    localparam int ST_SKIP = 6;
    localparam int RES_WR = 8;
    localparam int RES_HIGH_LSB = 16;
    localparam int PC_CYC_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [7:0] BCD_LIMIT = 8'h09;
    localparam logic [7:0] BCD_LOW_FIX = 8'h06;
    localparam logic [7:0] BCD_HIGH_FIX = 8'h60;

    typedef enum logic [4:0] {
        OP_NOP   = 5'b00000, OP_ADD   = 5'b00001, OP_ADC   = 5'b00010,
        OP_SUB   = 5'b00011, OP_SUBB  = 5'b00100, OP_BCD   = 5'b00101,
        OP_AND   = 5'b00110, OP_OR    = 5'b00111, OP_XOR   = 5'b01000,
        OP_INV   = 5'b01001, OP_INC   = 5'b01010, OP_DEC   = 5'b01011,
        OP_ROR   = 5'b01100, OP_ROL   = 5'b01101, OP_RORF  = 5'b01110,
        OP_ROLF  = 5'b01111, OP_LDW   = 5'b10000, OP_STW   = 5'b10001,
        OP_LDI   = 5'b10010, OP_BCLR  = 5'b10011, OP_BSET  = 5'b10100,
        OP_GOTO  = 5'b10101, OP_CALL  = 5'b10110, OP_EXIT  = 5'b10111,
        OP_IEXIT = 5'b11000, OP_SKZ   = 5'b11001, OP_SKBZ  = 5'b11010,
        OP_SKBNZ = 5'b11011, OP_TABRD = 5'b11100
    } mca_op_t;

    typedef struct packed {
        logic                                awReady;
        logic                                wReady;
        logic                                arReady;
        logic [ADDR_W-1:0]                   awAddr;
        logic                                awHeld;
        logic [31:0]                         wData;
        logic [3:0]                          wStrb;
        logic                                wHeld;
        logic                                bvalid;
        logic [1:0]                          bresp;
        logic                                rvalid;
        logic [31:0]                         rdata;
        logic [1:0]                          rresp;
        logic [7:0]                          wreg;
        logic [7:0]                          operand;
        logic [15:0]                         tableWord;
        logic [7:0]                          tableHigh;
        logic [7:0]                          memResult;
        logic                                memWrite;
        logic                                z;
        logic                                c;
        logic                                nib;
        logic                                sgn;
        logic                                gate;
        logic                                busy;
        logic                                skipped;
        logic [1:0]                          clkPhase;
        logic [1:0]                          cyclesLeft;
        logic [1:0]                          lastCycles;
        logic [PC_W-1:0]                     pc;
        logic [SP_W-1:0]                     sp;
        logic [STACK_DEPTH-1:0][PC_W-1:0]    stack;
    } mca_state_t;
endpackage

/* File: mca_core.sv */
// Execution datapath of the 8-bit core with cycle timing, behind an AXI4-Lite slave.
`timescale 1ns/100ps
`default_nettype none
module mca_core
    import mca_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready
);
    mca_state_t r;
    mca_state_t next_r;

    // Returns {signed wrap, nibble wrap, carry, result}; for subtraction the
    // carry and nibble outputs read high on a borrow.
    function automatic logic [10:0] addSub(input logic [7:0] a, input logic [7:0] b,
                                           input logic cin, input logic sub);
        logic [7:0] bx;
        logic [4:0] lo;
        logic [8:0] full;
        logic       ovf;
        bx = sub ? ~b : b;
        lo = 5'(a[3:0]) + 5'(bx[3:0]) + 5'(cin ^ sub);
        full = 9'(a) + 9'(bx) + 9'(cin ^ sub);
        ovf = (a[7] == bx[7]) && (full[7] != a[7]);
        return {ovf, lo[4] ^ sub, full[8] ^ sub, full[7:0]};
    endfunction

    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    logic            issueNow;
    mca_op_t         issueOp;
    assign issueNow = r.awHeld && r.wHeld && !r.bvalid && r.awAddr == OFF_CMD && !r.busy;
    assign issueOp = mca_op_t'(r.wData[CMD_OP_LSB +: 5]);

    always_comb begin
        logic [31:0]     d;
        logic [7:0]      o;
        logic [7:0]      res;
        logic [10:0]     as;
        logic [8:0]      bcd;
        logic [2:0]      bitIx;
        logic [1:0]      cyc;
        logic            hasRes;
        logic            toMem;
        logic            skip;
        logic [PC_W-1:0] nextPc;
        d = '0;
        o = r.operand;
        res = '0;
        as = '0;
        bcd = '0;
        bitIx = '0;
        cyc = 2'd1;
        hasRes = 1'b0;
        toMem = 1'b0;
        skip = 1'b0;
        nextPc = r.pc + PC_W'(1);
        next_r = r;
        if (awvalid && r.awReady) begin
            next_r.awAddr = awaddr;
            next_r.awHeld = 1'b1;
        end
        if (wvalid && r.wReady) begin
            next_r.wData = wdata;
            next_r.wStrb = wstrb;
            next_r.wHeld = 1'b1;
        end
        if (r.bvalid && bready) begin
            next_r.bvalid = 1'b0;
        end
        if (r.rvalid && rready) begin
            next_r.rvalid = 1'b0;
        end
        if (r.busy) begin
            next_r.clkPhase = r.clkPhase + 2'd1;
            if (r.clkPhase == PHASE_LAST) begin
                if (r.cyclesLeft == 2'd0) begin
                    next_r.busy = 1'b0;
                end else begin
                    next_r.cyclesLeft = r.cyclesLeft - 2'd1;
                end
            end
        end
        if (r.awHeld && r.wHeld && !r.bvalid) begin
            next_r.awHeld = 1'b0;
            next_r.wHeld = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = RESP_OKAY;
            case (r.awAddr)
                OFF_CMD: d = laneMerge(32'h0000_0000, r.wData, r.wStrb);
                OFF_OPND: begin
                    d = laneMerge({24'h00_0000, r.operand}, r.wData, r.wStrb);
                    next_r.operand = d[7:0];
                end
                OFF_TABLE: begin
                    d = laneMerge({16'h0000, r.tableWord}, r.wData, r.wStrb);
                    next_r.tableWord = d[15:0];
                end
                OFF_WREG: begin
                    d = laneMerge({24'h00_0000, r.wreg}, r.wData, r.wStrb);
                    if (!r.busy) begin
                        next_r.wreg = d[7:0];
                    end
                end
                OFF_STATUS: begin
                    d = laneMerge(32'h0000_0000, r.wData, r.wStrb);
                    if (!r.busy && r.wStrb[0]) begin
                        next_r.z = d[ST_Z];
                        next_r.c = d[ST_C];
                        next_r.nib = d[ST_NIB];
                        next_r.sgn = d[ST_SGN];
                        next_r.gate = d[ST_GATE];
                    end
                end
                OFF_PC: begin
                    d = laneMerge({20'h0_0000, r.pc}, r.wData, r.wStrb);
                    if (!r.busy) begin
                        next_r.pc = d[PC_W-1:0];
                    end
                end
                OFF_RESULT: d = '0;
                default: next_r.bresp = RESP_SLVERR;
            endcase
        end
        if (issueNow) begin
            bitIx = r.wData[CMD_BIT_LSB +: 3];
            toMem = r.wData[CMD_TOMEM];
            next_r.memWrite = 1'b0;
            case (issueOp)
                OP_ADD, OP_ADC, OP_SUB, OP_SUBB: begin
                    // Both immediate and memory forms take the byte from the operand register.
                    as = addSub(r.wreg, o, (issueOp == OP_ADC || issueOp == OP_SUBB) && r.c,
                                issueOp == OP_SUB || issueOp == OP_SUBB);
                    res = as[7:0];
                    hasRes = 1'b1;
                    next_r.c = as[8];
                    next_r.nib = as[9];
                    next_r.sgn = as[10];
                    next_r.z = (res == 8'h00);
                end
                OP_BCD: begin
                    bcd = {1'b0, r.wreg};
                    if (r.wreg[3:0] > BCD_LIMIT[3:0] || r.nib) begin
                        bcd = bcd + {1'b0, BCD_LOW_FIX};
                    end
                    if (bcd[7:4] > BCD_LIMIT[3:0] || r.c || bcd[8]) begin
                        bcd = {1'b0, bcd[7:0]} + {1'b0, BCD_HIGH_FIX} + {bcd[8], 8'h00};
                    end
                    res = bcd[7:0];
                    hasRes = 1'b1;
                    toMem = 1'b1;
                    next_r.c = r.c | bcd[8];
                end
                OP_AND, OP_OR, OP_XOR, OP_INV, OP_INC, OP_DEC: begin
                    case (issueOp)
                        OP_AND: res = r.wreg & o;
                        OP_OR: res = r.wreg | o;
                        OP_XOR: res = r.wreg ^ o;
                        OP_INV: res = ~o;
                        OP_INC: res = o + 8'h01;
                        default: res = o - 8'h01;
                    endcase
                    hasRes = 1'b1;
                    next_r.z = (res == 8'h00);
                end
                OP_ROR, OP_ROL: begin
                    res = (issueOp == OP_ROR) ? {o[0], o[7:1]} : {o[6:0], o[7]};
                    hasRes = 1'b1;
                end
                OP_RORF, OP_ROLF: begin
                    res = (issueOp == OP_RORF) ? {r.c, o[7:1]} : {o[6:0], r.c};
                    next_r.c = (issueOp == OP_RORF) ? o[0] : o[7];
                    hasRes = 1'b1;
                end
                OP_LDW, OP_LDI: begin
                    res = o;
                    hasRes = 1'b1;
                    toMem = 1'b0;
                end
                OP_STW: begin
                    res = r.wreg;
                    hasRes = 1'b1;
                    toMem = 1'b1;
                end
                OP_BCLR, OP_BSET: begin
                    res = o;
                    res[bitIx] = (issueOp == OP_BSET);
                    hasRes = 1'b1;
                    toMem = 1'b1;
                end
                OP_GOTO: begin
                    nextPc = r.wData[CMD_TGT_LSB +: PC_W];
                    cyc = 2'd2;
                end
                OP_CALL: begin
                    next_r.stack[r.sp] = r.pc + PC_W'(1);
                    next_r.sp = r.sp + SP_W'(1);
                    nextPc = r.wData[CMD_TGT_LSB +: PC_W];
                    cyc = 2'd2;
                end
                OP_EXIT, OP_IEXIT: begin
                    next_r.sp = r.sp - SP_W'(1);
                    nextPc = r.stack[r.sp - SP_W'(1)];
                    next_r.gate = r.gate | (issueOp == OP_IEXIT);
                    cyc = 2'd2;
                end
                OP_SKZ, OP_SKBZ, OP_SKBNZ: begin
                    case (issueOp)
                        OP_SKZ: skip = (o == 8'h00);
                        OP_SKBZ: skip = !o[bitIx];
                        default: skip = o[bitIx];
                    endcase
                    if (skip) begin
                        nextPc = r.pc + PC_W'(2);
                        cyc = 2'd2;
                    end
                end
                OP_TABRD: begin
                    res = r.tableWord[7:0];
                    next_r.tableHigh = r.tableWord[15:8];
                    hasRes = 1'b1;
                    toMem = 1'b1;
                    cyc = 2'd2;
                end
                default: begin
                    res = '0;
                end
            endcase
            if (hasRes && toMem) begin
                next_r.memResult = res;
                next_r.memWrite = 1'b1;
                if (r.wData[CMD_TOPCL]) begin
                    nextPc = {r.pc[PC_W-1:8], res};
                    cyc = cyc + 2'd1;
                end
            end else if (hasRes) begin
                next_r.wreg = res;
            end
            next_r.pc = nextPc;
            next_r.skipped = skip;
            next_r.busy = 1'b1;
            next_r.clkPhase = 2'd0;
            next_r.cyclesLeft = cyc - 2'd1;
            next_r.lastCycles = cyc;
        end
        if (arvalid && r.arReady) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = RESP_OKAY;
            next_r.rdata = '0;
            case (araddr)
                OFF_CMD: next_r.rdata = '0;
                OFF_OPND: next_r.rdata[7:0] = r.operand;
                OFF_TABLE: next_r.rdata[15:0] = r.tableWord;
                OFF_WREG: next_r.rdata[7:0] = r.wreg;
                OFF_STATUS: begin
                    next_r.rdata[ST_Z] = r.z;
                    next_r.rdata[ST_C] = r.c;
                    next_r.rdata[ST_NIB] = r.nib;
                    next_r.rdata[ST_SGN] = r.sgn;
                    next_r.rdata[ST_GATE] = r.gate;
                    next_r.rdata[ST_BUSY] = r.busy;
                    next_r.rdata[ST_SKIP] = r.skipped;
                end
                OFF_RESULT: begin
                    next_r.rdata[7:0] = r.memResult;
                    next_r.rdata[RES_WR] = r.memWrite;
                    next_r.rdata[RES_HIGH_LSB +: 8] = r.tableHigh;
                end
                OFF_PC: begin
                    next_r.rdata[PC_W-1:0] = r.pc;
                    next_r.rdata[PC_CYC_LSB +: 2] = r.lastCycles;
                end
                default: next_r.rresp = RESP_SLVERR;
            endcase
        end
        next_r.awReady = !next_r.awHeld;
        next_r.wReady = !next_r.wHeld;
        next_r.arReady = !next_r.rvalid;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign awready = r.awReady;
    assign wready = r.wReady;
    assign bvalid = r.bvalid;
    assign bresp = r.bresp;
    assign arready = r.arReady;
    assign rvalid = r.rvalid;
    assign rdata = r.rdata;
    assign rresp = r.rresp;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_one_cycle;
        issueNow && issueOp == OP_ADD && !r.wData[CMD_TOMEM] |=> r.busy [*4] ##1 !r.busy;
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("one-cycle op not 4 clocks");
    property p_goto_two;
        issueNow && issueOp == OP_GOTO |=> r.busy [*8] ##1 !r.busy;
    endproperty
    a_goto_two: assert property (p_goto_two) else $error("goto not 8 clocks");
    property p_pcl_extra;
        issueNow && issueOp == OP_ADD && r.wData[CMD_TOMEM] && r.wData[CMD_TOPCL]
            |=> r.lastCycles == 2'd2 && r.pc[7:0] == r.memResult;
    endproperty
    a_pcl_extra: assert property (p_pcl_extra) else $error("pointer write timing wrong");
    property p_skip_two;
        issueNow && issueOp == OP_SKZ && r.operand == 8'h00
            |=> r.busy [*8] ##1 !r.busy;
    endproperty
    a_skip_two: assert property (p_skip_two) else $error("taken skip not 8 clocks");
    property p_add_carry;
        issueNow && issueOp == OP_ADD && !r.wData[CMD_TOMEM]
            |=> r.c == ((9'($past(r.wreg)) + 9'($past(r.operand))) > 9'd255);
    endproperty
    a_add_carry: assert property (p_add_carry) else $error("add carry wrong");
    property p_logic_flags;
        issueNow && issueOp == OP_AND && !r.wData[CMD_TOMEM]
            |=> $stable(r.c) && $stable(r.sgn) && $stable(r.nib) && r.z == (r.wreg == 8'h00);
    endproperty
    a_logic_flags: assert property (p_logic_flags) else $error("logic flags wrong");
    property p_rotate_flags;
        issueNow && (issueOp == OP_ROR || issueOp == OP_ROL)
            |=> $stable(r.z) && $stable(r.c) && $stable(r.nib) && $stable(r.sgn);
    endproperty
    a_rotate_flags: assert property (p_rotate_flags) else $error("rotate changed flag");
    property p_iexit_gate;
        issueNow && issueOp == OP_IEXIT |=> r.gate;
    endproperty
    a_iexit_gate: assert property (p_iexit_gate) else $error("gate not opened");
    property p_exit_gate;
        issueNow && issueOp == OP_EXIT |=> r.gate == $past(r.gate);
    endproperty
    a_exit_gate: assert property (p_exit_gate) else $error("plain exit changed gate");
    property p_call_push;
        issueNow && issueOp == OP_CALL
            |=> r.stack[$past(r.sp)] == $past(r.pc) + PC_W'(1);
    endproperty
    a_call_push: assert property (p_call_push) else $error("return point lost");
endmodule
`default_nettype wire

/* File: mca_bench.sv */
// Self-checking bench for the core datapath, driven over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module mcu_core_alu_and_cycle_timing_bench;
    import mca_pkg::*;
    localparam mca_op_t OPS[16] = '{OP_ADD, OP_ADC, OP_SUB, OP_SUBB, OP_AND, OP_OR, OP_XOR,
        OP_INV, OP_INC, OP_DEC, OP_ROR, OP_ROL, OP_RORF, OP_ROLF, OP_LDW, OP_LDI};
    logic              core_clk = 1'b0;
    logic              sys_rst = 1'b1;
    logic [ADDR_W-1:0] awaddr = '0;
    logic [ADDR_W-1:0] araddr = '0;
    logic [31:0]       wdata = '0;
    logic [31:0]       rdata;
    logic [3:0]        wstrb = 4'hF;
    logic [1:0]        bresp, rresp;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic              rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [31:0]       expq[$];
    logic [11:0]       e;
    logic [31:0]       rv;
    int                miscompares = 0, cmp_count = 0;
    always #50 core_clk = ~core_clk;
    mca_core dut (.core_clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up(input int hung);
        miscompares += hung;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Each task waits one edge first so no handshake line is assigned twice in a time step.
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 200);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
        if (n >= 200) wrap_up(1);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] x,
                      input logic [1:0] er = RESP_OKAY);
        int n;
        @(posedge core_clk);
        expq.push_back(x);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 200);
        rready <= 1'b0;
        chk({30'h0, rresp}, {30'h0, er});
        if (n >= 200) wrap_up(1);
    endtask
    always @(posedge core_clk) begin
        if (rvalid === 1'b1 && rready === 1'b1 && expq.size() > 0) chk(rdata, expq.pop_front());
    end
    // Returns {signed, nibble, carry, zero, result}; carry means borrow on subtraction.
    function automatic logic [11:0] model(input mca_op_t op, input logic [7:0] w,
        input logic [7:0] o, input logic [3:0] f);
        logic sb, ci, sg;
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] r;
        sb = (op == OP_SUB || op == OP_SUBB);
        ci = (op == OP_ADC || op == OP_SUBB) ? f[1] : 1'b0;
        s = sb ? {1'b0, w} - o - ci : {1'b0, w} + o + ci;
        h = sb ? {1'b0, w[3:0]} - o[3:0] - ci : {1'b0, w[3:0]} + o[3:0] + ci;
        sg = (w[7] ^ o[7] ^ !sb) & (s[7] ^ w[7]);
        case (op)
            OP_AND: r = w & o;
            OP_OR: r = w | o;
            OP_XOR: r = w ^ o;
            OP_INV: r = ~o;
            OP_INC: r = o + 8'h01;
            OP_DEC: r = o - 8'h01;
            OP_ROR: return {f, o[0], o[7:1]};
            OP_ROL: return {f, o[6:0], o[7]};
            OP_RORF: return {f[3:2], o[0], f[0], f[1], o[7:1]};
            OP_ROLF: return {f[3:2], o[7], f[0], o[6:0], f[1]};
            OP_LDW, OP_LDI: return {f, o};
            default: return {sg, h[4], s[8], s[7:0] == 8'h00, s[7:0]};
        endcase
        return {f[3:1], r == 8'h00, r};
    endfunction
    // Sixteen clocks cover the longest instruction of three cycles after the response.
    task automatic step(input logic [31:0] c, input logic [4:0] a, input logic [31:0] x);
        wr(OFF_CMD, c, RESP_OKAY);
        repeat (16) @(posedge core_clk);
        rd(a, x);
    endtask
    initial begin
        void'($urandom(22));
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(5'h1C, 32'h0, RESP_SLVERR);
        wr(5'h1C, 32'h0, RESP_SLVERR);
        foreach (OPS[i]) begin
            rv = $urandom;
            wr(OFF_WREG, {24'h0, rv[7:0]}, RESP_OKAY);
            wr(OFF_OPND, {24'h0, rv[15:8]}, RESP_OKAY);
            wr(OFF_STATUS, {28'h0, rv[19:16]}, RESP_OKAY);
            wr(OFF_PC, 32'h0, RESP_OKAY);
            e = model(OPS[i], rv[7:0], rv[15:8], rv[19:16]);
            step({27'h0, OPS[i]}, OFF_PC, 32'h0001_0001);
            rd(OFF_WREG, {24'h0, e[7:0]});
            rd(OFF_STATUS, {28'h0, e[11:8]});
        end
        wr(OFF_WREG, 32'h38, RESP_OKAY);
        wr(OFF_OPND, 32'h45, RESP_OKAY);
        wr(OFF_STATUS, 32'h2, RESP_OKAY);
        foreach (OPS[i]) begin
            e = model(OPS[i], 8'h38, 8'h45, 4'h2);
            step({27'h0, OPS[i]}, OFF_STATUS, {28'h0, e[11:8]});
            rd(OFF_WREG, {24'h0, e[7:0]});
            wr(OFF_WREG, 32'h38, RESP_OKAY);
            wr(OFF_STATUS, 32'h2, RESP_OKAY);
        end
        wr(OFF_WREG, 32'h75, RESP_OKAY);
        wr(OFF_OPND, 32'h48, RESP_OKAY);
        wr(OFF_STATUS, 32'h0, RESP_OKAY);
        step(32'h01, OFF_WREG, 32'hBD);
        step(32'h05, OFF_RESULT, 32'h0000_0123);
        rd(OFF_STATUS, 32'hA);
        rd(OFF_WREG, 32'hBD);
        wr(OFF_WREG, 32'h38, RESP_OKAY);
        wr(OFF_OPND, 32'h45, RESP_OKAY);
        wr(OFF_STATUS, 32'h0, RESP_OKAY);
        step(32'h11, OFF_RESULT, 32'h0000_0138);
        wr(OFF_TABLE, 32'hA55A, RESP_OKAY);
        step(32'h61, OFF_RESULT, 32'h0000_017D);
        rd(OFF_PC, 32'h0002_007D);
        step(32'h0714, OFF_RESULT, 32'h0000_01C5);
        step(32'h0213, OFF_RESULT, 32'h0000_0141);
        step(32'h02A5_0015, OFF_PC, 32'h0002_02A5);
        step(32'h0123_0016, OFF_PC, 32'h0002_0123);
        step(32'h17, OFF_PC, 32'h0002_02A6);
        rd(OFF_STATUS, 32'h0);
        step(32'h0123_0016, OFF_PC, 32'h0002_0123);
        step(32'h18, OFF_STATUS, 32'h10);
        rd(OFF_PC, 32'h0002_02A7);
        wr(OFF_OPND, 32'h0, RESP_OKAY);
        step(32'h19, OFF_PC, 32'h0002_02A9);
        step(32'h031B, OFF_PC, 32'h0001_02AA);
        step(32'h021A, OFF_PC, 32'h0002_02AC);
        rd(OFF_STATUS, 32'h50);
        step(32'h1C, OFF_RESULT, 32'h00A5_015A);
        wrap_up(0);
    end
endmodule
`default_nettype wire
